// *** pkg/seg_check_params.svh ***
// Purpose: Offsets, field positions, reset values and codes of the checker.
// Assumes: Included by the checker module, the assertions and the testbench.
// Notes: Definitions only.
`ifndef SEG_CHECK_PARAMS_SVH
`define SEG_CHECK_PARAMS_SVH

// Register byte offsets on the APB.
`define OFS_CMD 8'h00
`define OFS_SELECTOR 8'h04
`define OFS_DESC 8'h08
`define OFS_LIMITS 8'h0C
`define OFS_OPERAND 8'h10
`define OFS_FLAGS 8'h14
`define OFS_FLAGS_NEW 8'h18
`define OFS_STATUS 8'h1C
`define OFS_LEVEL 8'h20
`define OFS_STACK 8'h24
`define OFS_SAVED_STACK 8'h28
`define OFS_TASK_STACK0 8'h2C
`define OFS_TASK_STACK1 8'h30
`define OFS_TASK_STACK2 8'h34

// Exception vectors.
`define VEC_NOT_PRESENT 8'h0B
`define VEC_STACK 8'h0C
`define VEC_GENERAL 8'h0D

// Flag word field positions.
`define FLAG_IF_BIT 9
`define FLAG_IO_LVL_HI 14
`define FLAG_IO_LVL_LO 13

// System descriptor type codes.
`define TYPE_TASK_FREE 4'h1
`define TYPE_TASK_BUSY 4'h3
`define TYPE_CALL_GATE 4'h4
`define TYPE_TASK_GATE 4'h5
`define TYPE_INT_GATE 4'h6
`define TYPE_TRAP_GATE 4'h7

// Reset values.
`define RST_LEVEL 2'h0
`define RST_FLAGS 16'h0000
`define RST_WORD 32'h00000000

`endif

// *** pkg/seg_check_pkg.sv ***
// Purpose: Types shared by the protection checker.
// Assumes: Constants live in seg_check_params.svh.
// Notes: Packed structs match the register field layout.
package seg_check_pkg;

  // Selector: table index, table indicator, requested privilege.
  typedef struct packed {
    logic [12:0] index;
    logic table_ind;
    logic [1:0] req_level;
  } selector_type;

  // Descriptor access byte plus gate fields in DESC bits 15:8.
  typedef struct packed {
    logic [1:0] dest_level;
    logic dest_task;
    logic [4:0] word_count;
    logic present;
    logic [1:0] level;
    logic seg;
    logic [3:0] kind;
  } desc_type;

  // Check commands written to CMD.
  typedef enum logic [3:0] {
    OP_NONE, OP_LOAD_DATA, OP_LOAD_STACK, OP_JUMP, OP_CALL, OP_RET,
    OP_INT_RETURN, OP_INT, OP_OPERAND, OP_PRIV, OP_IO, OP_POP_FLAGS
  } op_type;

  // Outcome of one check.
  typedef struct packed {
    logic [4:0] copy_count;
    logic [1:0] new_level;
    logic pop_old_stack;
    logic stack_switch;
    logic task_switch;
    logic [7:0] vector;
    logic fault;
  } result_type;

endpackage

// *** rtl/segment_privilege_checker.sv ***
// Purpose: Protection checks on selector loads, transfers and operands.
// Assumes: APB master on sys_clk; software supplies the descriptor.
// Notes: One check per CMD write; result ready one edge later.
// Operation
// - Data register loads accept only data or readable code descriptors.
// - Data load faults 13 if descriptor level below max of current, requested.
// - Readable conforming code loads as data at any privilege level.
// - Not-present descriptor on data register load gives vector 11.
// - Stack load needs writable data, both levels equal current, else 13.
// - Not-present stack load or stack operand gives vector 12.
// - Each transfer kind needs its descriptor type, else 13.
// - Direct jump or call needs matching or conforming privilege; selector too.
// - Returns never go inward; requested level becomes current; pop old stack on level change.
// - Free task segment not more privileged than current switches task on jump or call, else 13.
// - Gate more privileged than current raises 13.
// - Gate target level at most current, becomes current; task target switches.
// - Privilege change within task loads stack from task copy, saves old.
// - Privilege-raising call through gate copies its word count.
// - I/O privilege field is flag bits 14 and 13.
// - Flag restore keeps interrupt bit and I/O field when underprivileged.
// - Segment loads fault 13 on table limit, privilege or type errors.
// - Invalid types per target register raise 13.
// - Code writes, execute-only reads, read-only writes raise 13.
// - Limit overflow gives 12 on stack else 13; offset carry counts as overflow.
// - Table, task, machine word loads, flag clear, halt need level 0.
// - I/O, interrupt flag and lock need current at most I/O level.
`include "seg_check_params.svh"

module segment_privilege_checker (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Check outcome towards the core.
  output logic fault_pulse,
  output logic [7:0] fault_vector,
  output logic [1:0] current_priv_level
);

  logic rst_meta_ff;
  logic rst_sync_n_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic fault_pulse_ff;
  logic [7:0] fault_vector_ff;
  logic [1:0] cur_priv_ff;
  seg_check_pkg::op_type op_ff;
  seg_check_pkg::selector_type sel_ff;
  seg_check_pkg::desc_type desc_ff;
  logic [31:0] limits_ff;
  logic [17:0] operand_ff;
  logic [15:0] flags_ff;
  logic [15:0] flags_new_ff;
  seg_check_pkg::result_type result_ff;
  logic [31:0] stack_ff;
  logic [31:0] saved_stack_ff;
  logic [31:0] task_stack_ff [0:2];
  seg_check_pkg::result_type nxt_result;
  logic [15:0] nxt_flags;
  logic setup;
  logic wr_access;
  logic start;
  logic [1:0] epl;
  logic [1:0] io_priv_field;
  logic table_bad;
  logic [15:0] op_end;
  logic limit_bad;

  // Numeric maximum of two privilege levels.
  function automatic logic [1:0] priv_max(input logic [1:0] a,
                                          input logic [1:0] b);
    priv_max = (a > b) ? a : b;
  endfunction

  // Known register offset check, used by the error path.
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= `OFS_TASK_STACK2);
  endfunction

  // Reset is released through two flops so that release is glitch free.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_n_ff <= rst_meta_ff;
    end
  end

  assign setup = psel && !penable;
  assign wr_access = psel && penable && pready_ff && pwrite;
  assign start = wr_access && (paddr == `OFS_CMD);
  assign epl = priv_max(cur_priv_ff, sel_ff.req_level);
  assign io_priv_field = flags_ff[`FLAG_IO_LVL_HI:`FLAG_IO_LVL_LO];
  // Table entries are eight bytes; the last byte must be within the limit.
  assign table_bad = {sel_ff.index, 3'h7} > limits_ff[15:0];
  // The sum is cut to 16 bits; a carry out leaves it below the start offset.
  assign op_end = operand_ff[15:0] + {14'h0000, operand_ff[17:16]};
  assign limit_bad = (op_end > limits_ff[31:16]) ||
                     (op_end < operand_ff[15:0]);

  // APB answers with one wait-free access phase; data is set up early.
  always_ff @(posedge sys_clk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= `RST_WORD;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup && !mapped(paddr);
      if (setup && !pwrite) begin
        case (paddr)
          `OFS_CMD: prdata_ff <= {28'h0000000, op_ff};
          `OFS_SELECTOR: prdata_ff <= {16'h0000, sel_ff};
          `OFS_DESC: prdata_ff <= {16'h0000, desc_ff};
          `OFS_LIMITS: prdata_ff <= limits_ff;
          `OFS_OPERAND: prdata_ff <= {14'h0000, operand_ff};
          `OFS_FLAGS: prdata_ff <= {16'h0000, flags_ff};
          `OFS_FLAGS_NEW: prdata_ff <= {16'h0000, flags_new_ff};
          `OFS_STATUS: prdata_ff <= {13'h0000, result_ff};
          `OFS_LEVEL: prdata_ff <= {30'h00000000, cur_priv_ff};
          `OFS_STACK: prdata_ff <= stack_ff;
          `OFS_SAVED_STACK: prdata_ff <= saved_stack_ff;
          `OFS_TASK_STACK0: prdata_ff <= task_stack_ff[0];
          `OFS_TASK_STACK1: prdata_ff <= task_stack_ff[1];
          `OFS_TASK_STACK2: prdata_ff <= task_stack_ff[2];
          default: prdata_ff <= `RST_WORD;
        endcase
      end
    end
  end

  // Operand registers written by software before a command.
  always_ff @(posedge sys_clk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      op_ff <= seg_check_pkg::OP_NONE;
      sel_ff <= '0;
      desc_ff <= '0;
      limits_ff <= `RST_WORD;
      operand_ff <= '0;
      flags_new_ff <= `RST_FLAGS;
      task_stack_ff[0] <= `RST_WORD;
      task_stack_ff[1] <= `RST_WORD;
      task_stack_ff[2] <= `RST_WORD;
    end else if (wr_access) begin
      case (paddr)
        `OFS_CMD: op_ff <= seg_check_pkg::op_type'(pwdata[3:0]);
        `OFS_SELECTOR: sel_ff <= pwdata[15:0];
        `OFS_DESC: desc_ff <= pwdata[15:0];
        `OFS_LIMITS: limits_ff <= pwdata;
        `OFS_OPERAND: operand_ff <= pwdata[17:0];
        `OFS_FLAGS_NEW: flags_new_ff <= pwdata[15:0];
        `OFS_TASK_STACK0: task_stack_ff[0] <= pwdata;
        `OFS_TASK_STACK1: task_stack_ff[1] <= pwdata;
        `OFS_TASK_STACK2: task_stack_ff[2] <= pwdata;
        default: ;
      endcase
    end
  end

  // The check itself; the command comes straight from the write data so
  // that the result is ready at the same edge the command is taken.
  always_comb begin
    nxt_result = '0;
    nxt_result.new_level = cur_priv_ff;
    nxt_result.vector = `VEC_GENERAL;
    case (seg_check_pkg::op_type'(pwdata[3:0]))
      seg_check_pkg::OP_LOAD_DATA: begin
        if (table_bad) nxt_result.fault = 1'b1;
        else if (!desc_ff.seg || (desc_ff.kind[3] && !desc_ff.kind[1]))
          nxt_result.fault = 1'b1;
        else if (!(desc_ff.kind[3] && desc_ff.kind[2]) && desc_ff.level < epl)
          nxt_result.fault = 1'b1;
        else if (!desc_ff.present) begin
          nxt_result.fault = 1'b1;
          nxt_result.vector = `VEC_NOT_PRESENT;
        end
      end
      seg_check_pkg::OP_LOAD_STACK: begin
        if (table_bad) nxt_result.fault = 1'b1;
        else if (!desc_ff.seg || desc_ff.kind[3] || !desc_ff.kind[1])
          nxt_result.fault = 1'b1;
        else if (desc_ff.level != cur_priv_ff ||
                 sel_ff.req_level != cur_priv_ff)
          nxt_result.fault = 1'b1;
        else if (!desc_ff.present) begin
          nxt_result.fault = 1'b1;
          nxt_result.vector = `VEC_STACK;
        end
      end
      seg_check_pkg::OP_JUMP, seg_check_pkg::OP_CALL,
      seg_check_pkg::OP_INT: begin
        if (table_bad && pwdata[3:0] != seg_check_pkg::OP_INT)
          nxt_result.fault = 1'b1;
        else if (desc_ff.seg) begin
          // Interrupts only go through gates; data cannot enter CS.
          if (pwdata[3:0] == seg_check_pkg::OP_INT || !desc_ff.kind[3])
            nxt_result.fault = 1'b1;
          else if ((desc_ff.kind[2] ? desc_ff.level > cur_priv_ff
                                    : desc_ff.level != cur_priv_ff) ||
                   sel_ff.req_level > cur_priv_ff)
            nxt_result.fault = 1'b1;
          else if (!desc_ff.present) begin
            nxt_result.fault = 1'b1;
            nxt_result.vector = `VEC_NOT_PRESENT;
          end
        end else if (desc_ff.level < cur_priv_ff)
          nxt_result.fault = 1'b1;
        else if (!desc_ff.present) begin
          nxt_result.fault = 1'b1;
          nxt_result.vector = `VEC_NOT_PRESENT;
        end else begin
          case (desc_ff.kind)
            `TYPE_TASK_FREE: begin
              nxt_result.fault = (pwdata[3:0] == seg_check_pkg::OP_INT);
              nxt_result.task_switch = !nxt_result.fault;
            end
            `TYPE_TASK_GATE: nxt_result.task_switch = 1'b1;
            `TYPE_CALL_GATE, `TYPE_INT_GATE, `TYPE_TRAP_GATE: begin
              // Call gates serve CALL only, the others jumps and interrupts.
              if ((desc_ff.kind == `TYPE_CALL_GATE) !=
                  (pwdata[3:0] == seg_check_pkg::OP_CALL))
                nxt_result.fault = 1'b1;
              else if (desc_ff.dest_task)
                nxt_result.task_switch = 1'b1;
              else if (desc_ff.dest_level > cur_priv_ff)
                nxt_result.fault = 1'b1;
              else begin
                nxt_result.new_level = desc_ff.dest_level;
                if (desc_ff.dest_level != cur_priv_ff) begin
                  nxt_result.stack_switch = 1'b1;
                  if (desc_ff.kind == `TYPE_CALL_GATE)
                    nxt_result.copy_count = desc_ff.word_count;
                end
              end
            end
            // A busy task segment is refused as well.
            default: nxt_result.fault = 1'b1;
          endcase
        end
      end
      seg_check_pkg::OP_RET, seg_check_pkg::OP_INT_RETURN: begin
        if (table_bad) nxt_result.fault = 1'b1;
        else if (!desc_ff.seg || !desc_ff.kind[3])
          nxt_result.fault = 1'b1;
        else if (desc_ff.level < cur_priv_ff ||
                 sel_ff.req_level < cur_priv_ff)
          nxt_result.fault = 1'b1;
        else if (!desc_ff.present) begin
          nxt_result.fault = 1'b1;
          nxt_result.vector = `VEC_NOT_PRESENT;
        end else begin
          nxt_result.new_level = sel_ff.req_level;
          nxt_result.pop_old_stack = (sel_ff.req_level != cur_priv_ff);
        end
      end
      seg_check_pkg::OP_OPERAND: begin
        if (operand_ff[16] ? (desc_ff.kind[3] || !desc_ff.kind[1])
                           : (desc_ff.kind[3] && !desc_ff.kind[1]))
          nxt_result.fault = 1'b1;
        else if (limit_bad) begin
          nxt_result.fault = 1'b1;
          nxt_result.vector = operand_ff[17] ? `VEC_STACK
                                             : `VEC_GENERAL;
        end else if (operand_ff[17] && !desc_ff.present) begin
          nxt_result.fault = 1'b1;
          nxt_result.vector = `VEC_STACK;
        end
      end
      seg_check_pkg::OP_PRIV:
        nxt_result.fault = (cur_priv_ff != 2'h0);
      seg_check_pkg::OP_IO:
        nxt_result.fault = (cur_priv_ff > io_priv_field);
      default: ;
    endcase
    if (!nxt_result.fault) nxt_result.vector = 8'h00;
  end

  // Restored flag word with silent protection of IF and the I/O field.
  always_comb begin
    nxt_flags = flags_new_ff;
    if (cur_priv_ff > io_priv_field)
      nxt_flags[`FLAG_IF_BIT] = flags_ff[`FLAG_IF_BIT];
    if (cur_priv_ff != 2'h0)
      nxt_flags[`FLAG_IO_LVL_HI:`FLAG_IO_LVL_LO] = io_priv_field;
  end

  // Result, privilege, flag and stack state follow each command.
  always_ff @(posedge sys_clk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      result_ff <= '0;
      fault_pulse_ff <= 1'b0;
      fault_vector_ff <= 8'h00;
      cur_priv_ff <= `RST_LEVEL;
      flags_ff <= `RST_FLAGS;
      stack_ff <= `RST_WORD;
      saved_stack_ff <= `RST_WORD;
    end else begin
      fault_pulse_ff <= start && nxt_result.fault;
      if (start) begin
        result_ff <= nxt_result;
        fault_vector_ff <= nxt_result.vector;
      end
      if (start && !nxt_result.fault) begin
        cur_priv_ff <= nxt_result.new_level;
        if (pwdata[3:0] == seg_check_pkg::OP_POP_FLAGS ||
            pwdata[3:0] == seg_check_pkg::OP_INT_RETURN)
          flags_ff <= nxt_flags;
        if (nxt_result.stack_switch) begin
          saved_stack_ff <= stack_ff;
          stack_ff <= task_stack_ff[nxt_result.new_level];
        end
      end else if (wr_access) begin
        // Software may seed level, flags and stack outside commands.
        case (paddr)
          `OFS_LEVEL: cur_priv_ff <= pwdata[1:0];
          `OFS_FLAGS: flags_ff <= pwdata[15:0];
          `OFS_STACK: stack_ff <= pwdata;
          default: ;
        endcase
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign fault_pulse = fault_pulse_ff;
  assign fault_vector = fault_vector_ff;
  assign current_priv_level = cur_priv_ff;

endmodule // segment_privilege_checker

// *** verification/seg_check_sva.sv ***
// Purpose: Port-level assertions for the protection checker.
// Assumes: Zero-wait APB slave; one check per command write.
// Notes: Bound into the design top by the statement at the foot.
`include "seg_check_params.svh"

module seg_check_sva (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Check outcome.
  input wire logic fault_pulse,
  input wire logic [7:0] fault_vector,
  input wire logic [1:0] current_priv_level
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // A command write completes at this edge; results follow one edge later.
  logic cmd_wr;
  assign cmd_wr = psel && penable && pready && pwrite && (paddr == `OFS_CMD);

  AST_READY_NO_WAIT: assert property (psel && !penable |=> pready)
    else $error("pready missing in access phase");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_UNMAPPED_ERR: assert property (psel && !penable &&
    (paddr > 8'h34 || paddr[1:0] != 2'h0) |=> pslverr)
    else $error("unmapped access not refused");
  AST_PULSE_SINGLE: assert property (fault_pulse |=> !fault_pulse)
    else $error("fault pulse longer than one cycle");
  AST_PULSE_CAUSE: assert property (fault_pulse |-> $past(cmd_wr))
    else $error("fault pulse without command");
  AST_PULSE_VECTOR: assert property (cmd_wr |=>
    (fault_pulse == (fault_vector != 8'h00)))
    else $error("fault pulse and vector disagree");
  AST_VECTOR_HOLD: assert property (!cmd_wr |=> $stable(fault_vector))
    else $error("vector changed without command");
  AST_VECTOR_CODES: assert property (fault_pulse |-> fault_vector inside
    {`VEC_NOT_PRESENT, `VEC_STACK, `VEC_GENERAL})
    else $error("illegal fault vector");
  AST_PRIV_INSTR: assert property (cmd_wr && pwdata[3:0] == 4'h9 &&
    current_priv_level != 2'h0 |=> fault_pulse &&
    fault_vector == `VEC_GENERAL)
    else $error("privileged instruction allowed");
  AST_LEVEL_CAUSE: assert property ($changed(current_priv_level) |->
    $past(psel && penable && pwrite &&
    (paddr == `OFS_CMD || paddr == `OFS_LEVEL)))
    else $error("privilege changed without cause");

  // Main fault kinds seen.
  cover property (fault_pulse && fault_vector == `VEC_NOT_PRESENT);
  cover property (fault_pulse && fault_vector == `VEC_STACK);
  cover property (fault_pulse && fault_vector == `VEC_GENERAL);
endmodule // seg_check_sva

bind segment_privilege_checker seg_check_sva u_sva (
  .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .fault_pulse(fault_pulse),
  .fault_vector(fault_vector), .current_priv_level(current_priv_level));

// *** verification/testbench.sv ***
// Purpose: Self-checking bench for the protection checker over APB.
// Assumes: Descriptor layout and op codes as the block defines them.
// Notes: Each check writes level, selector, descriptor, limits and operand, issues the command, reads STATUS.
`include "seg_check_params.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic fault_pulse;
  logic [7:0] fault_vector;
  logic [1:0] current_priv_level;
  logic [31:0] rd, st, lim_w, opnd_w;
  logic rerr;
  logic pulse;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;

  segment_privilege_checker dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fault_pulse(fault_pulse), .fault_vector(fault_vector),
    .current_priv_level(current_priv_level));

  always #5 sys_clk = ~sys_clk;

  task automatic complete_run();
    if (err_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // A hung handshake would stall the run, so a cycle ceiling ends it.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic cmp(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB transfer; read data and error taken at the ready edge.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic [1:0] lvl, input logic [15:0] sel,
    input logic [15:0] desc, input logic [3:0] op, input logic [7:0] vec);
    apb(1'b1, `OFS_LEVEL, {30'h0, lvl});
    apb(1'b1, `OFS_SELECTOR, {16'h0, sel});
    apb(1'b1, `OFS_DESC, {16'h0, desc});
    apb(1'b1, `OFS_LIMITS, lim_w);
    apb(1'b1, `OFS_OPERAND, opnd_w);
    apb(1'b1, `OFS_CMD, {28'h0, op});
    // The fault pulse stands only in the cycle after the command edge.
    @(posedge sys_clk);
    pulse = fault_pulse;
    apb(1'b0, `OFS_STATUS, 32'h0);
    st = rd;
    cmp("status", {23'h0, vec, vec != 8'h00}, {23'h0, st[8:0]});
    cmp("fault pulse", {31'h0, vec != 8'h00}, {31'h0, pulse});
    cmp("fault vector", {24'h0, vec}, {24'h0, fault_vector});
  endtask

  task automatic test_bus();
    apb(1'b0, `OFS_LEVEL, 32'h0);
    cmp("level reset", 32'h0, rd);
    apb(1'b0, 8'h38, 32'h0);
    cmp("unmapped", 32'h1, {rd[30:0], rerr});
    apb(1'b0, 8'h05, 32'h0);
    cmp("unaligned", 32'h1, {rd[30:0], rerr});
  endtask

  task automatic test_data();
    chk(2'h0, 16'h0008, 16'h0092, 4'h1, 8'h00);
    chk(2'h2, 16'h0008, 16'h00B2, 4'h1, 8'h0D);
    chk(2'h0, 16'h000B, 16'h00D2, 4'h1, 8'h0D);
    chk(2'h3, 16'h000B, 16'h009E, 4'h1, 8'h00);
    chk(2'h0, 16'h0008, 16'h0098, 4'h1, 8'h0D);
    chk(2'h0, 16'h0008, 16'h00E4, 4'h1, 8'h0D);
    chk(2'h0, 16'h0008, 16'h0012, 4'h1, 8'h0B);
    lim_w = 32'hFFFF0000;
    chk(2'h0, 16'h0320, 16'h0092, 4'h1, 8'h0D);
    lim_w = 32'hFFFFFFFF;
  endtask

  task automatic test_stack();
    chk(2'h1, 16'h0009, 16'h00B2, 4'h2, 8'h00);
    chk(2'h1, 16'h0009, 16'h00B0, 4'h2, 8'h0D);
    chk(2'h1, 16'h0009, 16'h00BA, 4'h2, 8'h0D);
    chk(2'h1, 16'h0008, 16'h00B2, 4'h2, 8'h0D);
    chk(2'h1, 16'h0009, 16'h0032, 4'h2, 8'h0C);
  endtask

  task automatic test_xfer();
    chk(2'h2, 16'h000A, 16'h00E4, 4'h3, 8'h0D);
    chk(2'h2, 16'h000A, 16'h00DA, 4'h3, 8'h00);
    chk(2'h2, 16'h000A, 16'h00BA, 4'h3, 8'h0D);
    chk(2'h2, 16'h000A, 16'h009E, 4'h4, 8'h00);
    chk(2'h2, 16'h000B, 16'h009E, 4'h4, 8'h0D);
    chk(2'h2, 16'h000B, 16'h00E1, 4'h5, 8'h0D);
    chk(2'h2, 16'h000B, 16'h00BA, 4'h5, 8'h0D);
    chk(2'h2, 16'h000B, 16'h00FA, 4'h5, 8'h00);
    cmp("ret level pop", 32'h7, {29'h0, st[13:11]});
    cmp("level port", 32'h3, {30'h0, current_priv_level});
    chk(2'h2, 16'h000A, 16'h00A1, 4'h3, 8'h0D);
    chk(2'h2, 16'h000A, 16'h00E1, 4'h3, 8'h00);
    cmp("task switch", 32'h1, {31'h0, st[9]});
    chk(2'h2, 16'h000A, 16'h00A4, 4'h4, 8'h0D);
    chk(2'h2, 16'h000A, 16'h00A6, 4'h7, 8'h0D);
    chk(2'h2, 16'h000A, 16'hC5E4, 4'h4, 8'h0D);
    chk(2'h2, 16'h000A, 16'h20E4, 4'h4, 8'h00);
    cmp("gate task", 32'h1, {31'h0, st[9]});
    apb(1'b1, `OFS_TASK_STACK0, 32'h00001234);
    apb(1'b1, `OFS_STACK, 32'h00005678);
    chk(2'h2, 16'h000A, 16'h05E4, 4'h4, 8'h00);
    cmp("copy count", 32'h5, {27'h0, st[18:14]});
    cmp("switch level", 32'h1, {29'h0, st[13:12], st[10]});
    apb(1'b0, `OFS_STACK, 32'h0);
    cmp("new stack", 32'h00001234, rd);
    apb(1'b0, `OFS_SAVED_STACK, 32'h0);
    cmp("saved stack", 32'h00005678, rd);
    chk(2'h2, 16'h000A, 16'h00E6, 4'h7, 8'h00);
    cmp("int gate", 32'h1, {26'h0, st[18:14], st[10]});
    chk(2'h2, 16'h000A, 16'h00E5, 4'h7, 8'h00);
    cmp("int task gate", 32'h1, {31'h0, st[9]});
    chk(2'h2, 16'h000A, 16'h00E3, 4'h3, 8'h0D);
  endtask

  // The size field doubles as the write and stack flags.
  task automatic test_operand();
    opnd_w = 32'h00010000;
    chk(2'h0, 16'h0008, 16'h009A, 4'h8, 8'h0D);
    chk(2'h0, 16'h0008, 16'h00B0, 4'h8, 8'h0D);
    opnd_w = 32'h00000000;
    chk(2'h0, 16'h0008, 16'h0098, 4'h8, 8'h0D);
    lim_w = 32'h0010FFFF;
    opnd_w = 32'h00000010;
    chk(2'h0, 16'h0008, 16'h0092, 4'h8, 8'h00);
    opnd_w = 32'h00000011;
    chk(2'h0, 16'h0008, 16'h0092, 4'h8, 8'h0D);
    opnd_w = 32'h00020010;
    chk(2'h0, 16'h0008, 16'h0092, 4'h8, 8'h0C);
    opnd_w = 32'h00020000;
    chk(2'h0, 16'h0008, 16'h0012, 4'h8, 8'h0C);
    lim_w = 32'hFFFFFFFF;
    opnd_w = 32'h0001FFFF;
    chk(2'h0, 16'h0008, 16'h0092, 4'h8, 8'h0D);
    opnd_w = 32'h00000000;
  endtask

  task automatic test_instr();
    chk(2'h0, 16'h0008, 16'h0092, 4'h9, 8'h00);
    chk(2'h1, 16'h0008, 16'h0092, 4'h9, 8'h0D);
    apb(1'b1, `OFS_FLAGS, 32'h00002000);
    chk(2'h1, 16'h0008, 16'h0092, 4'hA, 8'h00);
    chk(2'h2, 16'h0008, 16'h0092, 4'hA, 8'h0D);
    apb(1'b1, `OFS_FLAGS_NEW, 32'h00006200);
    chk(2'h2, 16'h0008, 16'h0092, 4'hB, 8'h00);
    apb(1'b0, `OFS_FLAGS, 32'h0);
    cmp("flags level2", 32'h00002000, rd);
    chk(2'h1, 16'h0008, 16'h0092, 4'hB, 8'h00);
    apb(1'b0, `OFS_FLAGS, 32'h0);
    cmp("flags level1", 32'h00002200, rd);
    chk(2'h0, 16'h0008, 16'h0092, 4'hB, 8'h00);
    apb(1'b0, `OFS_FLAGS, 32'h0);
    cmp("flags level0", 32'h00006200, rd);
    apb(1'b1, `OFS_FLAGS_NEW, 32'h00000000);
    chk(2'h3, 16'h000B, 16'h00FA, 4'h6, 8'h00);
    apb(1'b0, `OFS_FLAGS, 32'h0);
    cmp("flags return", 32'h00006000, rd);
  endtask

  // Reset for ten cycles, then allow the internal release to settle.
  initial begin
    lim_w = 32'hFFFFFFFF;
    opnd_w = 32'h00000000;
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    test_bus();
    test_data();
    test_stack();
    test_xfer();
    test_operand();
    test_instr();
    complete_run();
  end
endmodule // testbench
